// >>> sroc_pkg.sv
package sroc_pkg;
  // Stage count and layout
  localparam int unsigned STAGE_CNT      = 12;
  localparam int unsigned SENSE_CNT      = 14;
  localparam int unsigned HALF_CNT       = 7;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned STAGE_IDX_W    = 4;
  localparam int unsigned WORD_IDX_W     = 2;
  localparam int unsigned MEM_ADDR_W     = 6;
  localparam int unsigned CODE_W         = 7;
  // Register indices within one stage (three words a stage)
  localparam logic [1:0]  ROUTE_LOW_IDX  = 2'h0;
  localparam logic [1:0]  ROUTE_HIGH_IDX = 2'h1;
  localparam logic [1:0]  OFFSET_IDX     = 2'h2;
  // Byte map: stage s word w at STAGE_BASE + s*STAGE_STRIDE + 4*w
  localparam logic [11:0] STAGE_BASE     = 12'h000;
  localparam logic [11:0] STAGE_STRIDE   = 12'h010;
  // Own control and status words
  localparam logic [11:0] CTRL_ADDR      = 12'h100;
  localparam logic [11:0] STATUS_ADDR    = 12'h104;
  // Field positions
  localparam int unsigned MINUS_OFF_BIT  = 14;
  localparam int unsigned PLUS_OFF_BIT   = 15;
  localparam int unsigned MINUS_CODE_LSB = 0;
  localparam int unsigned MINUS_STEER    = 7;
  localparam int unsigned PLUS_CODE_LSB  = 8;
  localparam int unsigned PLUS_STEER     = 15;
  localparam int unsigned CTRL_RUN_BIT   = 4;
  // Reset values
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [3:0]  STAGE_RST      = 4'h0;
  // Route codes
  typedef enum logic [1:0] {
    ROUTE_OPEN  = 2'h0,
    ROUTE_MINUS = 2'h1,
    ROUTE_PLUS  = 2'h2,
    ROUTE_BIAS  = 2'h3
  } sroc_route_t;
  // Apply sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_APPLY = 3'b100
  } sroc_state_t;
endpackage

// >>> sroc_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Two-port word store, registered read data on each port
module sroc_mem
  import sroc_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  we_i,
  input  wire logic [MEM_ADDR_W-1:0] waddr_i,
  input  wire logic [WORD_W-1:0]     wdata_i,
  input  wire logic [MEM_ADDR_W-1:0] raddr_a_i,
  output logic      [WORD_W-1:0]     rdata_a_o,
  input  wire logic [MEM_ADDR_W-1:0] raddr_b_i,
  output logic      [WORD_W-1:0]     rdata_b_o
);
  logic [WORD_W-1:0] mem_ff [0:(1<<MEM_ADDR_W)-1];

  // No reset: contents are undefined until software writes them
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem_ff[raddr_a_i];
    rdata_b_o <= mem_ff[raddr_b_i];
  end
endmodule
`default_nettype wire

// >>> sroc_top.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sroc_top
  import sroc_pkg::*;
(
  input  wire logic                   REF_CLK_I,
  input  wire logic                   RESET_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [11:0]            PADDR_I,
  input  wire logic [31:0]            PWDATA_I,
  output logic      [31:0]            PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O,
  input  wire logic                   CONV_START_I,
  input  wire logic [STAGE_IDX_W-1:0] CONV_STAGE_I,
  output logic                        CONV_ACTIVE_O,
  output logic      [SENSE_CNT-1:0]   SENSE_TO_MINUS_O,
  output logic      [SENSE_CNT-1:0]   SENSE_TO_PLUS_O,
  output logic      [SENSE_CNT-1:0]   SENSE_TO_BIAS_O,
  output logic      [CODE_W-1:0]      MINUS_INPUT_CODE_O,
  output logic      [CODE_W-1:0]      PLUS_INPUT_CODE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic [STAGE_IDX_W-1:0] rd_stage;
  logic [1:0]             rd_word;
  logic                   stage_hit;
  logic                   ctrl_hit;
  logic                   status_hit;
  logic                   addr_ok;
  logic                   setup;
  logic                   access;
  logic                   wr_stage;
  logic [MEM_ADDR_W-1:0]  bus_maddr;

  // Byte address 0x000..0x0bf, word 3 of each stage is a hole
  assign rd_stage   = PADDR_I[7:4];
  assign rd_word    = PADDR_I[3:2];
  assign stage_hit  = (PADDR_I[11:8] == 4'h0) && (rd_stage < STAGE_CNT[3:0])
                      && (rd_word != 2'h3) && (PADDR_I[1:0] == 2'h0);
  assign ctrl_hit   = (PADDR_I == CTRL_ADDR);
  assign status_hit = (PADDR_I == STATUS_ADDR);
  assign addr_ok    = stage_hit || ctrl_hit || status_hit;
  assign setup      = PSEL_I && !PENABLE_I;
  assign access     = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_stage   = access && PWRITE_I && stage_hit;
  assign bus_maddr  = {rd_stage, rd_word};

  ////////////////////////////////////////////////////////////////////////////
  // Ready: reads need the memory's registered output, so access waits one cycle
  logic wait_ff;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= setup;
    end
  end

  assign PREADY_O  = PSEL_I && PENABLE_I && !wait_ff;
  assign PSLVERR_O = PREADY_O && !addr_ok; // Unmapped address answers with an error

  ////////////////////////////////////////////////////////////////////////////
  // Control word: run enable and reserved-bit hygiene for the low route word
  logic ctrl_run_ff;
  logic nxt_ctrl_run;

  assign nxt_ctrl_run = (access && PWRITE_I && ctrl_hit) ? PWDATA_I[CTRL_RUN_BIT] : ctrl_run_ff;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_run_ff <= 1'b0;
    end else begin
      ctrl_run_ff <= nxt_ctrl_run;
    end
  end

  // Unused bits of the low route word are forced to zero, guarding against hosts that skip it
  logic [WORD_W-1:0] wr_word;

  assign wr_word = (rd_word == ROUTE_LOW_IDX) ? {2'h0, PWDATA_I[13:0]} : PWDATA_I[WORD_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Apply sequencer: fetch three words of the converting stage, then drive
  sroc_state_t            state_ff;
  sroc_state_t            nxt_state;
  logic [STAGE_IDX_W-1:0] cur_stage_ff;
  logic [1:0]             fetch_idx_ff;
  logic [1:0]             nxt_fetch_idx;
  logic [1:0]             got_idx_ff;
  logic                   got_vld_ff;
  logic                   start_ok;
  logic [MEM_ADDR_W-1:0]  seq_maddr;
  logic [WORD_W-1:0]      bus_rdata;
  logic [WORD_W-1:0]      seq_rdata;

  assign start_ok  = CONV_START_I && ctrl_run_ff && (CONV_STAGE_I < STAGE_CNT[3:0]);
  assign seq_maddr = {cur_stage_ff, fetch_idx_ff};

  always_comb begin
    nxt_state     = state_ff;
    nxt_fetch_idx = fetch_idx_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_fetch_idx = ROUTE_LOW_IDX;
        if (start_ok) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_idx_ff == OFFSET_IDX) begin
          nxt_state = ST_APPLY;
        end else begin
          nxt_fetch_idx = fetch_idx_ff + 2'h1;
        end
      end
      ST_APPLY: begin
        // Stays driven until the run bit drops; a new start re-fetches
        if (!ctrl_run_ff) begin
          nxt_state = ST_IDLE;
        end else if (start_ok) begin
          nxt_state     = ST_FETCH;
          nxt_fetch_idx = ROUTE_LOW_IDX;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_ff     <= ST_IDLE;
      fetch_idx_ff <= 2'h0;
      cur_stage_ff <= STAGE_RST;
      got_idx_ff   <= 2'h0;
      got_vld_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      fetch_idx_ff <= nxt_fetch_idx;
      got_idx_ff   <= fetch_idx_ff;
      got_vld_ff   <= (state_ff == ST_FETCH);
      if (start_ok && (state_ff != ST_FETCH)) begin
        cur_stage_ff <= CONV_STAGE_I;
      end
    end
  end

  sroc_mem u_mem (
    .clk_i     (REF_CLK_I),
    .we_i      (wr_stage),
    .waddr_i   (bus_maddr),
    .wdata_i   (wr_word),
    .raddr_a_i (bus_maddr),
    .rdata_a_o (bus_rdata),
    .raddr_b_i (seq_maddr),
    .rdata_b_o (seq_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shadow words of the active stage, loaded as memory words return
  logic [WORD_W-1:0] sh_low_ff;
  logic [WORD_W-1:0] sh_high_ff;
  logic [WORD_W-1:0] sh_off_ff;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sh_low_ff  <= WORD_RST;
      sh_high_ff <= WORD_RST;
      sh_off_ff  <= WORD_RST;
    end else if (got_vld_ff) begin
      if (got_idx_ff == ROUTE_LOW_IDX) begin
        sh_low_ff <= seq_rdata;
      end
      if (got_idx_ff == ROUTE_HIGH_IDX) begin
        sh_high_ff <= seq_rdata;
      end
      if (got_idx_ff == OFFSET_IDX) begin
        sh_off_ff <= seq_rdata;
      end
    end
  end

  // Drive only once every word of the stage is in, so no mix of stages reaches the matrix
  logic drive_ff;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= (state_ff == ST_APPLY) && ctrl_run_ff && !start_ok;
    end
  end

  assign CONV_ACTIVE_O = drive_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Route decode, one field per sense input
  logic [SENSE_CNT-1:0] to_minus;
  logic [SENSE_CNT-1:0] to_plus;
  logic [SENSE_CNT-1:0] to_bias;

  genvar gi;
  generate
    for (gi = 0; gi < SENSE_CNT; gi++) begin : g_route
      logic [1:0] fld;
      if (gi < HALF_CNT) begin : g_lo
        assign fld = sh_low_ff[2*gi+1:2*gi];
      end else begin : g_hi
        assign fld = sh_high_ff[2*(gi-HALF_CNT)+1:2*(gi-HALF_CNT)];
      end
      // Code 00 sets none of the three, leaving the input open
      assign to_minus[gi] = drive_ff && (fld == ROUTE_MINUS);
      assign to_plus[gi]  = drive_ff && (fld == ROUTE_PLUS);
      assign to_bias[gi]  = drive_ff && (fld == ROUTE_BIAS);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Offset steering: each code lands on one converter input, or the higher one wins if both meet there
  logic [CODE_W-1:0] minus_code;
  logic [CODE_W-1:0] plus_code;
  logic              minus_en;
  logic              plus_en;
  logic [CODE_W-1:0] minus_on_minus;
  logic [CODE_W-1:0] minus_on_plus;
  logic [CODE_W-1:0] plus_on_plus;
  logic [CODE_W-1:0] plus_on_minus;

  assign minus_code     = sh_off_ff[MINUS_CODE_LSB +: CODE_W];
  assign plus_code      = sh_off_ff[PLUS_CODE_LSB +: CODE_W];
  assign minus_en       = drive_ff && !sh_high_ff[MINUS_OFF_BIT];
  assign plus_en        = drive_ff && !sh_high_ff[PLUS_OFF_BIT];
  assign minus_on_minus = (minus_en && !sh_off_ff[MINUS_STEER]) ? minus_code : 7'h00;
  assign minus_on_plus  = (minus_en &&  sh_off_ff[MINUS_STEER]) ? minus_code : 7'h00;
  assign plus_on_plus   = (plus_en  && !sh_off_ff[PLUS_STEER])  ? plus_code  : 7'h00;
  assign plus_on_minus  = (plus_en  &&  sh_off_ff[PLUS_STEER])  ? plus_code  : 7'h00;

  // Registered switch-matrix outputs; a shared input gets the higher of two codes (a maximum, not a sum)
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SENSE_TO_MINUS_O   <= '0;
      SENSE_TO_PLUS_O    <= '0;
      SENSE_TO_BIAS_O    <= '0;
      MINUS_INPUT_CODE_O <= 7'h00;
      PLUS_INPUT_CODE_O  <= 7'h00;
    end else begin
      SENSE_TO_MINUS_O   <= to_minus;
      SENSE_TO_PLUS_O    <= to_plus;
      SENSE_TO_BIAS_O    <= to_bias;
      MINUS_INPUT_CODE_O <= (minus_on_minus > plus_on_minus) ? minus_on_minus : plus_on_minus;
      PLUS_INPUT_CODE_O  <= (plus_on_plus > minus_on_plus) ? plus_on_plus : minus_on_plus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, registered in the wait cycle before the access cycle
  logic [31:0] rd_mux;

  assign rd_mux = stage_hit  ? {16'h0000, bus_rdata} :
                  ctrl_hit   ? {27'h0, ctrl_run_ff, 4'h0} :
                  status_hit ? {24'h0, state_ff, drive_ff, cur_stage_ff} :
                               32'h0000_0000;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && PENABLE_I && wait_ff) begin
      PRDATA_O <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_start;
    start_ok && (state_ff != ST_FETCH);
  endsequence

  sequence s_fetch_three;
    (state_ff == ST_FETCH) [*3] ##1 (state_ff == ST_APPLY);
  endsequence

  a_fetch_then_apply: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    s_start |=> s_fetch_three)
    else $error("stage fetch did not take three cycles");

  a_low_unused_zero: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    wr_stage && (rd_word == ROUTE_LOW_IDX) |-> wr_word[15:14] == 2'h0)
    else $error("reserved bits of low route word stored nonzero");

  a_open_route: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && (sh_low_ff[1:0] == ROUTE_OPEN) |=> !SENSE_TO_MINUS_O[0] && !SENSE_TO_PLUS_O[0] && !SENSE_TO_BIAS_O[0])
    else $error("open input was connected");

  a_minus_route: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && (sh_low_ff[3:2] == ROUTE_MINUS) |=> SENSE_TO_MINUS_O[1] && !SENSE_TO_PLUS_O[1])
    else $error("minus route not applied");

  a_plus_route: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && (sh_high_ff[13:12] == ROUTE_PLUS) |=> SENSE_TO_PLUS_O[13] && !SENSE_TO_MINUS_O[13])
    else $error("plus route not applied");

  a_bias_route: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && (sh_low_ff[13:12] == ROUTE_BIAS) |=> SENSE_TO_BIAS_O[6])
    else $error("bias route not applied");

  a_idle_quiet: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    !drive_ff |=> (SENSE_TO_MINUS_O == '0) && (SENSE_TO_PLUS_O == '0) && (MINUS_INPUT_CODE_O == 7'h00))
    else $error("matrix driven outside a conversion");

  a_minus_off: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && sh_high_ff[MINUS_OFF_BIT] && sh_high_ff[PLUS_OFF_BIT] |=> (MINUS_INPUT_CODE_O == 7'h00) && (PLUS_INPUT_CODE_O == 7'h00))
    else $error("disabled offsets still applied");

  a_plus_steer: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && !sh_high_ff[PLUS_OFF_BIT] && sh_high_ff[MINUS_OFF_BIT] && !sh_off_ff[PLUS_STEER]
    |=> PLUS_INPUT_CODE_O == $past(sh_off_ff[14:8]))
    else $error("plus offset code not on plus input");

  a_minus_code: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    drive_ff && !sh_high_ff[MINUS_OFF_BIT] && sh_high_ff[PLUS_OFF_BIT] && !sh_off_ff[MINUS_STEER]
    |=> MINUS_INPUT_CODE_O == $past(sh_off_ff[6:0]))
    else $error("minus offset code not on minus input");

endmodule
`default_nettype wire

// >>> sroc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sroc_top_tb;
  import sroc_pkg::*;

  typedef struct {
    logic [3:0]  s;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] off;
  } sroc_tb_row_t;

  logic        clk, rst, psel, penable, pwrite, start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, active;
  logic [3:0]  stage;
  logic [13:0] to_m, to_p, to_b, em, ep, eb;
  logic [6:0]  code_m, code_p, ecm, ecp;
  logic [31:0] rd;
  logic        err;
  int          errors, compares;
  sroc_tb_row_t rows [6];

  sroc_top dut (
    .REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CONV_START_I(start), .CONV_STAGE_I(stage), .CONV_ACTIVE_O(active),
    .SENSE_TO_MINUS_O(to_m), .SENSE_TO_PLUS_O(to_p), .SENSE_TO_BIAS_O(to_b),
    .MINUS_INPUT_CODE_O(code_m), .PLUS_INPUT_CODE_O(code_p)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One compare point; four-state equality so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[FAIL] %0t bus answer missing", $time);
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] waddr(input logic [3:0] s, input logic [1:0] w);
    return STAGE_BASE + STAGE_STRIDE * s + 12'(4 * w);
  endfunction

  // Expected switch matrix and offset codes for one stage's three words
  function automatic void model(input sroc_tb_row_t r);
    logic [27:0] f;
    logic [6:0]  mc, pc;
    f = {r.hi[13:0], r.lo[13:0]};
    em = '0; ep = '0; eb = '0; ecm = '0; ecp = '0;
    for (int i = 0; i < 14; i++) begin
      case (f[2*i +: 2])
        2'h1: em[i] = 1'b1;
        2'h2: ep[i] = 1'b1;
        2'h3: eb[i] = 1'b1;
        default: ;
      endcase
    end
    mc = r.hi[14] ? 7'h00 : r.off[6:0];
    pc = r.hi[15] ? 7'h00 : r.off[14:8];
    if (r.off[7]) ecp = mc; else ecm = mc;
    if (r.off[15]) begin
      if (pc > ecm) ecm = pc;
    end else begin
      if (pc > ecp) ecp = pc;
    end
  endfunction

  // Start a stage and wait for the matrix to settle
  task automatic conv(input logic [3:0] s);
    int n;
    @(posedge clk);
    start <= 1'b1;
    stage <= s;
    @(posedge clk);
    start <= 1'b0;
    // Looked at between edges, so the level left by the previous stage cannot end the wait early
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (active !== 1'b1 && n < 20);
    if (active !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t conversion never became active", $time);
      test_done();
    end
    chk(32'(n), 32'h5, "edges from start to active");
    // Matrix outputs follow the active flag by one edge
    @(negedge clk);
  endtask

  task automatic chk_out();
    chk(32'(to_m), 32'(em), "minus route");
    chk(32'(to_p), 32'(ep), "plus route");
    chk(32'(to_b), 32'(eb), "bias route");
    chk(32'(code_m), 32'(ecm), "minus code");
    chk(32'(code_p), 32'(ecp), "plus code");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    start = 1'b0; stage = '0; errors = 0; compares = 0;
    // Every route code, disable bit and steer bit appears in some row
    rows[0] = '{4'h0, 16'hc6e4, 16'h1b39, 16'h2a15};
    rows[1] = '{4'h5, 16'h3fff, 16'h4000, 16'h8a95};
    rows[2] = '{4'hb, 16'h1555, 16'haaaa, 16'h7f7f};
    rows[3] = '{4'h7, 16'h0000, 16'h0000, 16'h0483};
    rows[4] = '{4'h3, 16'h2d87, 16'hc000, 16'hffff};
    rows[5] = '{4'h9, 16'h0b1e, 16'h5247, 16'h3a11};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({3'h0, active, to_m, to_p}, 32'h0, "outputs after reset");
    chk({4'h0, code_m, code_p, to_b}, 32'h0, "codes after reset");
    // All six row stages written first so a neighbour's words cannot leak in
    foreach (rows[i]) begin
      apb(1'b1, waddr(rows[i].s, ROUTE_LOW_IDX), {18'h0, rows[i].lo[13:0]});
      apb(1'b1, waddr(rows[i].s, ROUTE_HIGH_IDX), {16'h0, rows[i].hi});
      apb(1'b1, waddr(rows[i].s, OFFSET_IDX), {16'h0, rows[i].off});
    end
    foreach (rows[i]) begin
      apb(1'b0, waddr(rows[i].s, ROUTE_LOW_IDX), 32'h0);
      chk(rd, {18'h0, rows[i].lo[13:0]}, "route low readback");
      apb(1'b0, waddr(rows[i].s, ROUTE_HIGH_IDX), 32'h0);
      chk(rd, {16'h0, rows[i].hi}, "route high readback");
      apb(1'b0, waddr(rows[i].s, OFFSET_IDX), 32'h0);
      chk(rd, {16'h0, rows[i].off}, "offset readback");
    end
    // Run bit clear: a start is ignored
    conv_idle();
    apb(1'b1, CTRL_ADDR, 32'h10);
    foreach (rows[i]) begin
      model(rows[i]);
      conv(rows[i].s);
      chk_out();
    end
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd & 32'h1f, {27'h0, 1'b1, rows[5].s}, "status stage");
    // Out-of-range stage leaves the last stage driving
    @(posedge clk);
    start <= 1'b1;
    stage <= 4'hc;
    @(posedge clk);
    start <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk_out();
    // Unmapped words answer with an error and read zero
    apb(1'b1, 12'h00c, 32'hffff);
    chk(32'(err), 32'h1, "unmapped write error");
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b0, waddr(4'hc, ROUTE_LOW_IDX), 32'h0);
    chk({31'h0, err}, 32'h1, "stage twelve unmapped");
    apb(1'b0, waddr(4'h0, ROUTE_LOW_IDX), 32'h0);
    chk({31'h0, err}, 32'h0, "mapped no error");
    // Reset in mid-conversion clears the matrix
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk({3'h0, active, to_m, to_p}, 32'h0, "outputs in reset");
    chk({4'h0, code_m, code_p, to_b}, 32'h0, "codes in reset");
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({3'h0, active, to_m, to_p}, 32'h0, "outputs after release");
    // Sequencer idle, nothing driven, stage zero
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h20, "status after reset");
    // Reset clears the run bit, so a start is ignored again
    conv_idle();
    test_done();
  end

  task automatic conv_idle();
    @(posedge clk);
    start <= 1'b1;
    stage <= 4'h0;
    @(posedge clk);
    start <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({31'h0, active}, 32'h0, "start without run");
  endtask

  // Whole run bounded
  initial begin
    #2000000;
    errors++;
    $display("[FAIL] %0t run too long", $time);
    test_done();
  end
endmodule
`default_nettype wire
